// [common/rvs_pkg.sv]
// Purpose: Shared constants and types for the reset-vector, status and config block.
// Assumes: 24-bit external address bus and 16-bit boot memory words.
// Notes: Register indices address 16-bit registers on the plain register port.
package rvs_pkg;
  // ------------------------------------------------------------------
  // Register port indices
  // ------------------------------------------------------------------
  localparam logic [2:0] REG_STATUS = 3'h0;
  localparam logic [2:0] REG_CONFIG = 3'h1;
  localparam logic [2:0] REG_VBR_HI = 3'h2;
  localparam logic [2:0] REG_VBR_LO = 3'h3;
  localparam logic [2:0] REG_BOOT = 3'h4;
  // ------------------------------------------------------------------
  // Status word layout
  // ------------------------------------------------------------------
  localparam int SR_TRACE_HI = 15;
  localparam int SR_TRACE_LO = 14;
  localparam int SR_SUPER = 13;
  localparam int SR_MASK_HI = 10;
  localparam int SR_MASK_LO = 8;
  localparam int SR_CCR_HI = 4;
  localparam logic [15:0] SR_RESET = 16'h2700;
  localparam logic [15:0] SR_VALID = 16'he71f;
  // ------------------------------------------------------------------
  // Configuration register layout
  // ------------------------------------------------------------------
  localparam int CFG_FREEZE_HALTS_SW_TIMERS = 14;
  localparam int CFG_FREEZE_HALTS_BUS_MONITOR = 13;
  localparam int CFG_MM = 6;
  localparam int CFG_INTERRUPT_ARBITRATION_VALUE_HI = 3;
  localparam logic [15:0] CFG_RESET = 16'h004f;
  localparam logic [15:0] CFG_VALID = 16'h604f;
  localparam logic [23:0] REGMAP_LOW = 24'h7f_f000;
  localparam logic [23:0] REGMAP_HIGH = 24'hff_f000;
  // ------------------------------------------------------------------
  // Vectors and fetch addresses
  // ------------------------------------------------------------------
  localparam logic [23:0] BOOT_BASE = 24'h00_0000;
  localparam logic [31:0] VBR_RESET = 32'h0000_0000;
  localparam logic [7:0] AUTOVEC_BASE = 8'h18;
  localparam logic [2:0] IRQ_NMI_LEVEL = 3'h7;
  localparam logic [1:0] BOOT_LAST_WORD = 2'h3;
  typedef enum logic [1:0] {ST_BOOT, ST_RUN, ST_VECTOR} seq_state_t;
endpackage : rvs_pkg

// [logic/reset_vector_status_sim_config.sv]
// Purpose: Reset vector sequencer, processor status word and system config register.
// Assumes: Boot memory answers on mclk; irq and freeze pins are asynchronous.
// Notes: Vector fetches hold mem_req until mem_ack; no wait limit is applied.
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/100ps
module reset_vector_status_sim_config (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic mem_req,
  output logic [23:0] mem_addr,
  output logic mem_program_space,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  output logic [31:0] stack_pointer,
  output logic [31:0] program_counter,
  output logic cpu_run,
  input wire logic instr_done,
  output logic trace_exc,
  input wire logic priv_access,
  output logic priv_fault,
  input wire logic exc_req,
  input wire logic [7:0] exc_vector,
  input wire logic rte_req,
  input wire logic [15:0] rte_status,
  input wire logic [31:0] rte_pc,
  input wire logic ccr_we,
  input wire logic [4:0] ccr_in,
  input wire logic [2:0] irq_pin_level,
  output logic irq_accept,
  output logic [2:0] irq_accept_level,
  output logic [3:0] irq_arb_value,
  input wire logic freeze_pin,
  output logic sw_timer_halt,
  output logic bus_monitor_halt,
  output logic [23:0] regmap_base
);
  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  rvs_pkg::seq_state_t state_q, state_d;
  logic [1:0] word_q, word_d;
  logic [7:0] vec_q, vec_d;
  logic [15:0] sr_q, sr_d, cfg_q, cfg_d;
  logic mm_locked_q, mm_locked_d;
  logic [31:0] vbr_q, vbr_d, sp_q, sp_d, pc_q, pc_d;
  logic [23:0] addr_next;
  logic [2:0] irq_s1_q, irq_s2_q, irq_prev_q;
  logic frz_s1_q, frz_s2_q;

  function automatic logic sel(input logic [2:0] a, input logic [2:0] idx);
    sel = (a == idx);
  endfunction : sel

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  wire sup_mode = sr_q[rvs_pkg::SR_SUPER];
  wire run = (state_q == rvs_pkg::ST_RUN);
  wire ack_take = mem_ack && mem_req;
  wire [2:0] mask = sr_q[rvs_pkg::SR_MASK_HI:rvs_pkg::SR_MASK_LO];
  wire rte_ok = run && rte_req && sup_mode;
  wire exc_take = run && exc_req && !rte_ok;
  // Level seven is taken on its rising edge so a held request cannot loop.
  wire nmi_edge = (irq_s2_q == rvs_pkg::IRQ_NMI_LEVEL) && (irq_prev_q != rvs_pkg::IRQ_NMI_LEVEL);
  wire irq_ok = nmi_edge || ((irq_s2_q != 3'h0) && (irq_s2_q > mask));
  wire irq_take = run && !exc_req && !rte_req && irq_ok;
  wire sr_wr = reg_wr && sel(reg_addr, rvs_pkg::REG_STATUS);
  wire cfg_wr = reg_wr && sup_mode && sel(reg_addr, rvs_pkg::REG_CONFIG);
  wire vbr_hi_wr = reg_wr && sup_mode && sel(reg_addr, rvs_pkg::REG_VBR_HI);
  wire vbr_lo_wr = reg_wr && sup_mode && sel(reg_addr, rvs_pkg::REG_VBR_LO);
  wire trace_on = (sr_q[rvs_pkg::SR_TRACE_HI:rvs_pkg::SR_TRACE_LO] != 2'b00);
  wire [7:0] autovec = rvs_pkg::AUTOVEC_BASE + {5'b0, irq_s2_q};
  wire [15:0] boot_word = {12'b0, run, word_q, 1'b0};
  wire [15:0] rd_mux = sel(reg_addr, rvs_pkg::REG_STATUS) ? sr_q :
                       sel(reg_addr, rvs_pkg::REG_CONFIG) ? cfg_q :
                       sel(reg_addr, rvs_pkg::REG_VBR_HI) ? vbr_q[31:16] :
                       sel(reg_addr, rvs_pkg::REG_VBR_LO) ? vbr_q[15:0] :
                       sel(reg_addr, rvs_pkg::REG_BOOT) ? boot_word : 16'h0000;

  // ------------------------------------------------------------------
  // Fetch sequencer
  // ------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    word_d = word_q;
    vec_d = vec_q;
    case (state_q)
      rvs_pkg::ST_BOOT: begin
        if (ack_take) begin
          word_d = word_q + 2'd1;
          if (word_q == rvs_pkg::BOOT_LAST_WORD) begin
            state_d = rvs_pkg::ST_RUN;
          end
        end
      end
      rvs_pkg::ST_VECTOR: begin
        if (ack_take) begin
          word_d = word_q[0] ? 2'd0 : 2'd1;
          if (word_q[0]) begin
            state_d = rvs_pkg::ST_RUN;
          end
        end
      end
      rvs_pkg::ST_RUN: begin
        if (exc_take) begin
          state_d = rvs_pkg::ST_VECTOR;
          vec_d = exc_vector;
          word_d = 2'd0;
        end else if (irq_take) begin
          state_d = rvs_pkg::ST_VECTOR;
          vec_d = autovec;
          word_d = 2'd0;
        end
      end
      default: begin
        state_d = rvs_pkg::ST_BOOT;
      end
    endcase
  end

  // Reset words always start at the fixed base; other vectors follow the base register.
  assign addr_next = (state_d == rvs_pkg::ST_BOOT) ?
                     rvs_pkg::BOOT_BASE + {21'b0, word_d, 1'b0} :
                     vbr_q[23:0] + {14'b0, vec_d, 2'b00} + {22'b0, word_d[0], 1'b0};

  // Loads of stack pointer and program counter from fetched halves.
  always_comb begin
    sp_d = sp_q;
    pc_d = pc_q;
    if (ack_take && state_q == rvs_pkg::ST_BOOT) begin
      case (word_q)
        2'd0: sp_d[31:16] = mem_rdata;
        2'd1: sp_d[15:0] = mem_rdata;
        2'd2: pc_d[31:16] = mem_rdata;
        default: pc_d[15:0] = mem_rdata;
      endcase
    end else if (ack_take && state_q == rvs_pkg::ST_VECTOR) begin
      if (word_q[0]) begin
        pc_d[15:0] = mem_rdata;
      end else begin
        pc_d[31:16] = mem_rdata;
      end
    end else if (rte_ok) begin
      pc_d = rte_pc;
    end
  end

  // ------------------------------------------------------------------
  // Status word, config and vector base
  // ------------------------------------------------------------------
  always_comb begin
    sr_d = sr_q;
    if (ccr_we) begin
      sr_d[rvs_pkg::SR_CCR_HI:0] = ccr_in;
    end
    if (sr_wr) begin
      // In user state only the flag bits may be written.
      sr_d = sup_mode ? (reg_wdata & rvs_pkg::SR_VALID) : {sr_q[15:5], reg_wdata[4:0]};
    end
    if (rte_ok) begin
      sr_d = rte_status & rvs_pkg::SR_VALID;
    end
    if (exc_take || irq_take) begin
      sr_d[rvs_pkg::SR_SUPER] = 1'b1;
      sr_d[rvs_pkg::SR_TRACE_HI:rvs_pkg::SR_TRACE_LO] = 2'b00;
    end
    if (irq_take) begin
      sr_d[rvs_pkg::SR_MASK_HI:rvs_pkg::SR_MASK_LO] = irq_s2_q;
    end
  end

  always_comb begin
    cfg_d = cfg_q;
    mm_locked_d = mm_locked_q | cfg_wr;
    if (cfg_wr) begin
      cfg_d = reg_wdata & rvs_pkg::CFG_VALID;
      cfg_d[rvs_pkg::CFG_MM] = mm_locked_q ? cfg_q[rvs_pkg::CFG_MM] : reg_wdata[rvs_pkg::CFG_MM];
    end
    vbr_d = vbr_q;
    if (vbr_hi_wr) begin
      vbr_d[31:16] = reg_wdata;
    end
    if (vbr_lo_wr) begin
      vbr_d[15:0] = reg_wdata;
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= rvs_pkg::ST_BOOT;
      word_q <= 2'd0;
      vec_q <= 8'h00;
      sr_q <= rvs_pkg::SR_RESET;
      cfg_q <= rvs_pkg::CFG_RESET;
      mm_locked_q <= 1'b0;
      vbr_q <= rvs_pkg::VBR_RESET;
      sp_q <= 32'h0000_0000;
      pc_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      word_q <= word_d;
      vec_q <= vec_d;
      sr_q <= sr_d;
      cfg_q <= cfg_d;
      mm_locked_q <= mm_locked_d;
      vbr_q <= vbr_d;
      sp_q <= sp_d;
      pc_q <= pc_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      mem_req <= 1'b0;
      mem_addr <= rvs_pkg::BOOT_BASE;
      mem_program_space <= 1'b1;
      cpu_run <= 1'b0;
      reg_rdata <= 16'h0000;
    end else begin
      mem_req <= (state_d != rvs_pkg::ST_RUN);
      mem_addr <= addr_next;
      mem_program_space <= (state_d == rvs_pkg::ST_BOOT);
      cpu_run <= (state_d == rvs_pkg::ST_RUN);
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  // Pins cross in through two flops; the second is read, and a third irq copy is read to find the level-seven edge.
  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_s1_q <= 3'h0;
      irq_s2_q <= 3'h0;
      irq_prev_q <= 3'h0;
      frz_s1_q <= 1'b0;
      frz_s2_q <= 1'b0;
    end else begin
      irq_s1_q <= irq_pin_level;
      irq_s2_q <= irq_s1_q;
      irq_prev_q <= irq_s2_q;
      frz_s1_q <= freeze_pin;
      frz_s2_q <= frz_s1_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      trace_exc <= 1'b0;
      priv_fault <= 1'b0;
      irq_accept <= 1'b0;
      irq_accept_level <= 3'h0;
      irq_arb_value <= rvs_pkg::CFG_RESET[3:0];
      sw_timer_halt <= 1'b0;
      bus_monitor_halt <= 1'b0;
      regmap_base <= rvs_pkg::REGMAP_HIGH;
    end else begin
      trace_exc <= run && instr_done && trace_on;
      priv_fault <= !sup_mode && (priv_access || rte_req || reg_wr);
      irq_accept <= irq_take;
      irq_accept_level <= irq_take ? irq_s2_q : 3'h0;
      irq_arb_value <= cfg_q[rvs_pkg::CFG_INTERRUPT_ARBITRATION_VALUE_HI:0];
      sw_timer_halt <= frz_s2_q && cfg_q[rvs_pkg::CFG_FREEZE_HALTS_SW_TIMERS];
      bus_monitor_halt <= frz_s2_q && cfg_q[rvs_pkg::CFG_FREEZE_HALTS_BUS_MONITOR];
      regmap_base <= cfg_q[rvs_pkg::CFG_MM] ? rvs_pkg::REGMAP_HIGH : rvs_pkg::REGMAP_LOW;
    end
  end

  assign stack_pointer = sp_q;
  assign program_counter = pc_q;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  property p_boot_addr;
    @(posedge mclk) disable iff (reset)
    (state_q == rvs_pkg::ST_BOOT && mem_req) |-> (mem_addr == {21'b0, word_q, 1'b0}) && mem_program_space;
  endproperty
  a_boot_addr: assert property (p_boot_addr) else $error("boot fetch address wrong");

  property p_sp_join;
    @(posedge mclk) disable iff (reset)
    (state_q == rvs_pkg::ST_BOOT && ack_take && word_q == 2'd1) |=>
      (sp_q[15:0] == $past(mem_rdata)) && $stable(sp_q[31:16]) && (word_q == 2'd2);
  endproperty
  a_sp_join: assert property (p_sp_join) else $error("stack pointer low half not joined");

  property p_boot_done;
    @(posedge mclk) disable iff (reset)
    (state_q == rvs_pkg::ST_BOOT && ack_take && word_q == 2'd3) |=> cpu_run && (pc_q[15:0] == $past(mem_rdata));
  endproperty
  a_boot_done: assert property (p_boot_done) else $error("run not entered after last boot word");

  property p_trace;
    @(posedge mclk) disable iff (reset)
    (run && instr_done && trace_on) |=> trace_exc ##1 !trace_exc || instr_done;
  endproperty
  a_trace: assert property (p_trace) else $error("trace exception missing");

  property p_reset_values;
    @(posedge mclk) disable iff (reset)
    $fell(reset) |-> (sr_q[15:8] == 8'h27) && (cfg_q[3:0] == 4'hf) && cfg_q[rvs_pkg::CFG_MM];
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("bad reset values");

  property p_irq_mask;
    @(posedge mclk) disable iff (reset)
    irq_accept |-> ($past(irq_s2_q) == 3'h7) || ($past(irq_s2_q) > $past(mask));
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt accepted");

  property p_mm_once;
    @(posedge mclk) disable iff (reset)
    (mm_locked_q && reg_wr && sel(reg_addr, rvs_pkg::REG_CONFIG)) |=> $stable(cfg_q[rvs_pkg::CFG_MM]);
  endproperty
  a_mm_once: assert property (p_mm_once) else $error("map bit changed after first write");

  property p_regmap;
    @(posedge mclk) disable iff (reset)
    ##1 1'b1 |-> regmap_base == ($past(cfg_q[rvs_pkg::CFG_MM]) ? 24'hff_f000 : 24'h7f_f000);
  endproperty
  a_regmap: assert property (p_regmap) else $error("register window base wrong");

  property p_user_fault;
    @(posedge mclk) disable iff (reset)
    (!sup_mode && (reg_wr || priv_access)) |=> priv_fault;
  endproperty
  a_user_fault: assert property (p_user_fault) else $error("user access not refused");

  property p_vec_addr;
    @(posedge mclk) disable iff (reset)
    (state_q == rvs_pkg::ST_VECTOR && mem_req) |->
      (mem_addr == vbr_q[23:0] + {14'b0, vec_q, 2'b00} + {22'b0, word_q[0], 1'b0}) && !mem_program_space;
  endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("vector fetch address wrong");

  property p_rte;
    @(posedge mclk) disable iff (reset)
    rte_ok |=> (pc_q == $past(rte_pc)) && (sr_q == ($past(rte_status) & rvs_pkg::SR_VALID));
  endproperty
  a_rte: assert property (p_rte) else $error("context not restored");
endmodule : reset_vector_status_sim_config

// [test/boot_memory_model.sv]
// Purpose: Boot memory on the far side of the vector fetch link.
// Assumes: Fetch link runs on mclk; one word per acknowledge.
// Notes: Answers after zero to three idle cycles, chosen at random.
`timescale 1ns/100ps
module boot_memory_model (
  input wire logic mclk,
  input wire logic reset,
  input wire logic mem_req,
  input wire logic [23:0] mem_addr,
  output logic [15:0] mem_rdata,
  output logic mem_ack
);
  int unsigned wait_left;

  // Content is a fixed function of the byte address, so the bench can predict every word.
  function automatic logic [15:0] word_of(input logic [23:0] addr);
    return addr[15:0] ^ 16'h5a3c;
  endfunction : word_of

  initial begin
    mem_ack = 1'b0;
    mem_rdata = 16'h0000;
    wait_left = 0;
  end

  // Outside an acknowledge the data lines toggle, so a stale word is never mistaken for valid.
  always @(posedge mclk) begin
    if (reset || mem_req !== 1'b1 || mem_ack === 1'b1) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_left <= $urandom_range(3, 0);
    end else if (wait_left == 0) begin
      mem_ack <= 1'b1;
      mem_rdata <= word_of(mem_addr);
    end else begin
      wait_left <= wait_left - 1;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : boot_memory_model

// [test/reset_vector_status_sim_config_tb.sv]
// Purpose: Self-checking bench for the reset vector, status and config block.
// Assumes: Boot memory model on the fetch link; registers over the plain port.
// Notes: Expected words come from the memory model's address function.
`timescale 1ns/100ps
module reset_vector_status_sim_config_tb;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic instr_done = 1'b0;
  logic priv_access = 1'b0;
  logic exc_req = 1'b0;
  logic [7:0] exc_vector = 8'h00;
  logic rte_req = 1'b0;
  logic [15:0] rte_status = 16'h0000;
  logic [31:0] rte_pc = 32'h0000_0000;
  logic ccr_we = 1'b0;
  logic [4:0] ccr_in = 5'h00;
  logic [2:0] irq_pin_level = 3'h0;
  logic freeze_pin = 1'b0;
  logic [15:0] reg_rdata, mem_rdata;
  logic mem_req, mem_program_space, mem_ack, cpu_run, trace_exc, priv_fault, irq_accept;
  logic sw_timer_halt, bus_monitor_halt;
  logic [23:0] mem_addr, regmap_base, aa;
  logic [31:0] stack_pointer, program_counter;
  logic [2:0] irq_accept_level, lvl;
  logic [3:0] irq_arb_value, arb;
  logic [15:0] rd;
  logic [7:0] vec;
  logic [4:0] ccr;
  logic exp_prog = 1'b1;
  logic [23:0] acked[$];
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;

  reset_vector_status_sim_config i_reset_vector_status_sim_config (
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_program_space(mem_program_space), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .stack_pointer(stack_pointer), .program_counter(program_counter), .cpu_run(cpu_run),
    .instr_done(instr_done), .trace_exc(trace_exc), .priv_access(priv_access),
    .priv_fault(priv_fault), .exc_req(exc_req), .exc_vector(exc_vector), .rte_req(rte_req),
    .rte_status(rte_status), .rte_pc(rte_pc), .ccr_we(ccr_we), .ccr_in(ccr_in),
    .irq_pin_level(irq_pin_level), .irq_accept(irq_accept),
    .irq_accept_level(irq_accept_level), .irq_arb_value(irq_arb_value),
    .freeze_pin(freeze_pin), .sw_timer_halt(sw_timer_halt),
    .bus_monitor_halt(bus_monitor_halt), .regmap_base(regmap_base)
  );

  boot_memory_model i_boot_memory_model (
    .mclk(mclk), .reset(reset), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack)
  );

  always #12.5 mclk = ~mclk;

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task finish_test;
    if (n_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  task check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task reg_write(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task reg_read(input logic [2:0] a, output logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read

  // One-cycle pulse on a control input; the flop outputs are settled on return.
  task kick(input int k);
    @(posedge mclk);
    case (k)
      0: instr_done <= 1'b1;
      1: priv_access <= 1'b1;
      2: ccr_we <= 1'b1;
      3: exc_req <= 1'b1;
      default: rte_req <= 1'b1;
    endcase
    @(posedge mclk);
    {instr_done, priv_access, ccr_we, exc_req, rte_req} <= 5'b0_0000;
    #1;
  endtask : kick

  task wait_run;
    int i;
    for (i = 0; i < 40 && cpu_run !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    check(cpu_run, 1'b1);
  endtask : wait_run

  task wait_acc(output logic [2:0] l, output logic [23:0] a);
    int i;
    l = 3'h0;
    a = 24'h00_0000;
    for (i = 0; i < 10; i++) begin
      @(posedge mclk);
      #1;
      if (irq_accept === 1'b1) begin
        l = irq_accept_level;
        a = mem_addr;
        return;
      end
    end
  endtask : wait_acc

  // ------------------------------------------------------------------
  // Fetch monitor and run limit
  // ------------------------------------------------------------------
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_errors++;
      finish_test();
    end
    if (mem_req === 1'b1 && mem_ack === 1'b1) begin
      acked.push_back(mem_addr);
      check(mem_program_space, exp_prog);
    end
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    int i;
    void'($urandom(32'h1aed));
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    wait_run;
    check(acked.size(), 4);
    for (i = 0; i < 4; i++) check(acked[i], 2 * i);
    check(stack_pointer, {i_boot_memory_model.word_of(0), i_boot_memory_model.word_of(2)});
    check(program_counter, {i_boot_memory_model.word_of(4), i_boot_memory_model.word_of(6)});
    reg_read(rvs_pkg::REG_STATUS, rd);
    check(rd, 16'h2700);
    reg_read(rvs_pkg::REG_BOOT, rd);
    check(rd, 16'h0008);
    kick(0);
    check(trace_exc, 1'b0);
    reg_read(rvs_pkg::REG_CONFIG, rd);
    check(rd, 16'h004f);
    check(irq_arb_value, 4'hf);
    check(regmap_base, 24'hff_f000);
    reg_read(rvs_pkg::REG_VBR_HI, rd);
    check(rd, 16'h0000);
    reg_write(3'h5, 16'hffff);
    reg_read(3'h5, rd);
    check(rd, 16'h0000);
    // Map bit cleared by the first write; the second write may not set it again.
    arb = 4'($urandom_range(15, 1));
    reg_write(rvs_pkg::REG_CONFIG, {12'h600, arb});
    freeze_pin <= 1'b1;
    reg_read(rvs_pkg::REG_CONFIG, rd);
    check(rd, {12'h600, arb});
    check(regmap_base, 24'h7f_f000);
    check(irq_arb_value, arb);
    repeat (3) @(posedge mclk);
    #1 check(sw_timer_halt, 1'b1);
    check(bus_monitor_halt, 1'b1);
    reg_write(rvs_pkg::REG_CONFIG, {12'h204, arb});
    reg_read(rvs_pkg::REG_CONFIG, rd);
    check(rd, {12'h200, arb});
    check(regmap_base, 24'h7f_f000);
    repeat (2) @(posedge mclk);
    #1 check(sw_timer_halt, 1'b0);
    check(bus_monitor_halt, 1'b1);
    freeze_pin <= 1'b0;
    ccr = 5'($urandom);
    ccr_in <= ccr;
    kick(2);
    reg_read(rvs_pkg::REG_STATUS, rd);
    check(rd, {11'h138, ccr});
    reg_write(rvs_pkg::REG_STATUS, 16'ha700);
    kick(0);
    check(trace_exc, 1'b1);
    reg_write(rvs_pkg::REG_VBR_HI, 16'h0001);
    reg_write(rvs_pkg::REG_VBR_LO, 16'h0000);
    vec = 8'($urandom_range(255, 64));
    aa = 24'h01_0000 + {14'h0000, vec, 2'b00};
    exc_vector <= vec;
    exp_prog <= 1'b0;
    kick(3);
    check(mem_addr, aa);
    check(cpu_run, 1'b0);
    wait_run;
    check(program_counter, {i_boot_memory_model.word_of(aa), i_boot_memory_model.word_of(aa + 2)});
    reg_read(rvs_pkg::REG_STATUS, rd);
    check(rd, 16'h2700);
    rte_status <= 16'h0300;
    rte_pc <= $urandom;
    kick(4);
    check(program_counter, rte_pc);
    reg_read(rvs_pkg::REG_STATUS, rd);
    check(rd, 16'h0300);
    kick(1);
    check(priv_fault, 1'b1);
    reg_write(rvs_pkg::REG_CONFIG, 16'h0000);
    reg_read(rvs_pkg::REG_CONFIG, rd);
    check(rd, {12'h200, arb});
    irq_pin_level <= 3'h2;
    wait_acc(lvl, aa);
    check(lvl, 3'h0);
    irq_pin_level <= 3'h5;
    wait_acc(lvl, aa);
    check(lvl, 3'h5);
    check(aa, 24'h01_0074);
    wait_run;
    reg_read(rvs_pkg::REG_STATUS, rd);
    check(rd, 16'h2500);
    irq_pin_level <= 3'h0;
    reg_write(rvs_pkg::REG_STATUS, 16'h2700);
    repeat (2) @(posedge mclk);
    irq_pin_level <= 3'h7;
    wait_acc(lvl, aa);
    check(lvl, 3'h7);
    check(aa, 24'h01_007c);
    wait_run;
    finish_test();
  end
endmodule : reset_vector_status_sim_config_tb
